/* logic/sdbt_timer.sv */
// Summary of operation
// [R1] prescale code 0..7 divides clock by 1,2,4,8,16,64,256,1024
// [R2] timer counts only while the enable bit is one
// [R3] dual byte mode bit makes two independent 8-bit down counters
// [R4] output enable bit puts the waveform on the pin instead of port
// [R5] while disabled the forced level bits drive the waveform outputs
// [R6] command field: none, reserved, restart, hard reset
// [R7] hard reset command is ignored while the timer is enabled
// [R8] command field always reads zero in set and clear registers
// [R9] command target: none, reserved, reserved, both counters
// [R10] software writes command with target; command acts on selected counters
// [R11] software selects both counters when issuing hard reset
// [R12] clear register: ones clear target bits, zeros leave them
// [R13] set register: ones set target bits, zeros leave them
// [R14] low compare enable lets its flag raise that channel's request
// [R15] bottom enables let the bottom flags raise their requests
// [R16] low count equal to channel compare value sets its flag
// [R17] flags stay set until software writes one; set beats clear
// [R18] high counter reaching bottom sets the high bottom flag
// [R19] low counter reaching bottom sets the low bottom flag
// [R20] high compare values drive high waveform outputs while enabled
// [R21] counters step down per tick, reload period at zero, flag bottom
`timescale 1ns/1ns
`default_nettype none
module sdbt_timer
(
  input  wire logic [sdbt_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [sdbt_pkg::DATA_W-1:0] regWdata,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [5:0]                  portOut,
  output logic      [sdbt_pkg::DATA_W-1:0] regRdata,
  output logic      [5:0]                  waveOut,
  output logic      [5:0]                  pinOut,
  output logic      [2:0]                  lowMatchIrq,
  output logic                             highBottomIrq,
  output logic                             lowBottomIrq
);
  import sdbt_pkg::*;

  logic [7:0]   ctrlClk;
  logic [7:0]   outEn;
  logic [7:0]   forced;
  logic [7:0]   splitCtl;
  logic [1:0]   cmdTarget;
  logic [7:0]   intEn;
  logic [7:0]   interrupt_flags;
  logic [7:0]   lowCnt;
  logic [7:0]   highCnt;
  logic [7:0]   lowPer;
  logic [7:0]   highPer;
  logic [7:0]   lowCmp [0:2];
  logic [7:0]   highCmp [0:2];
  logic [7:0]   readValue;
  logic [7:0]   flagSet;
  logic [7:0]   flagClr;
  logic [1:0]   next_target;
  logic [5:0]   chanEn;
  logic [2:0]   lowMatch;
  logic         timerOn;
  logic         counting;
  logic         tick;
  logic         wrCmd;
  logic         wrLowCnt;
  logic         wrHighCnt;
  logic         wrCmp;
  logic         restartCmd;
  logic         hardReset;
  logic         clrAll;
  logic         lowStep;
  logic         highStep;
  logic         lowBottom;
  logic         highBottom;
  logic [1:0]   cmpIdx;
  sdbt_cmd_t    cmdCode;

  // step one count down, wrapping to the period at zero
  function automatic logic [7:0] stepDown(input logic [7:0] cnt,
                                          input logic [7:0] per);
    stepDown = (cnt == 8'h00) ? per : 8'(cnt - 8'h01); // R21
  endfunction

  // compare channel index of a compare register offset
  function automatic logic [1:0] indexOf(input logic [5:0] addr);
    logic [5:0] rel;
    rel = 6'(addr - OFF_CMP_FIRST);
    indexOf = rel[2:1];
  endfunction

  // run state and prescaler
  assign timerOn  = ctrlClk[ENABLE_BIT]; // R2
  assign counting = timerOn && splitCtl[SPLIT_BIT]; // R2 R3

  sdbt_prescaler #(
    .PRESC_W (PRESC_W)
  ) u_presc (
    .mclk    (mclk),
    .rst     (clrAll),
    .run     (counting),
    .restart (restartCmd),
    .select  (ctrlClk[PRESC_LSB +: 3]),
    .tick    (tick)
  );

  // command decode on writes to the set and clear registers
  assign wrCmd   = regWrite &&
                   (regAddr == OFF_CMD_CLR || regAddr == OFF_CMD_SET);
  assign cmdCode = sdbt_cmd_t'(regWdata[CMD_LSB +: 2]); // R6
  assign next_target = (regAddr == OFF_CMD_SET) ?
                       (cmdTarget | regWdata[TARGET_LSB +: 2]) : // R13
                       (cmdTarget & ~regWdata[TARGET_LSB +: 2]); // R12
  assign restartCmd = wrCmd && cmdCode == CMD_RESTART &&
                      next_target == TGT_BOTH; // R6 R9 R10
  assign hardReset  = wrCmd && cmdCode == CMD_HARD_RESET &&
                      next_target == TGT_BOTH && !timerOn; // R7 R11
  assign clrAll     = rst || hardReset;

  // address strobes for the counting registers
  assign wrLowCnt  = regWrite && regAddr == OFF_LOW_CNT;
  assign wrHighCnt = regWrite && regAddr == OFF_HIGH_CNT;
  assign wrCmp     = regWrite && regAddr >= OFF_CMP_FIRST &&
                     regAddr <= OFF_CMP_LAST;
  assign cmpIdx    = indexOf(regAddr);

  // control registers, reserved bits held at zero
  always_ff @(posedge mclk)
  begin
    if (clrAll)
    begin
      ctrlClk  <= RST_REG;
      outEn    <= RST_REG;
      forced   <= RST_REG;
      splitCtl <= RST_REG;
      intEn    <= RST_REG;
    end
    else if (regWrite)
    begin
      if (regAddr == OFF_CTRL_CLK)
        ctrlClk <= regWdata & CTRL_MASK;
      else if (regAddr == OFF_OUT_EN)
        outEn <= regWdata & CHAN_MASK;
      else if (regAddr == OFF_FORCED)
        forced <= regWdata & CHAN_MASK;
      else if (regAddr == OFF_SPLIT)
        splitCtl <= regWdata & SPLIT_MASK; // R3
      else if (regAddr == OFF_INT_EN)
        intEn <= regWdata & IRQ_MASK;
    end
  end

  // command target bits, set or cleared by writing ones
  always_ff @(posedge mclk)
  begin
    if (clrAll)
      cmdTarget <= TGT_NONE;
    else if (wrCmd)
      cmdTarget <= next_target; // R12 R13
  end

  // period and compare storage
  always_ff @(posedge mclk)
  begin
    if (clrAll)
    begin
      lowPer  <= RST_PER;
      highPer <= RST_PER;
      for (int i = 0; i < 3; i++)
      begin
        lowCmp[i]  <= RST_CMP;
        highCmp[i] <= RST_CMP;
      end
    end
    else if (regWrite && regAddr == OFF_LOW_PER)
      lowPer <= regWdata;
    else if (regWrite && regAddr == OFF_HIGH_PER)
      highPer <= regWdata;
    else if (wrCmp && !regAddr[0])
      lowCmp[cmpIdx] <= regWdata;
    else if (wrCmp)
      highCmp[cmpIdx] <= regWdata;
  end

  // counter events; a software write beats count and restart
  assign lowStep    = tick && counting && !wrLowCnt && !restartCmd;
  assign highStep   = tick && counting && !wrHighCnt && !restartCmd;
  assign lowBottom  = lowStep && lowCnt == 8'h00; // R19
  assign highBottom = highStep && highCnt == 8'h00; // R18
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      lowMatch[i] = lowStep && lowCnt == lowCmp[i]; // R16
  end

  // low byte down counter
  always_ff @(posedge mclk)
  begin
    if (clrAll)
      lowCnt <= RST_CNT;
    else if (wrLowCnt)
      lowCnt <= regWdata;
    else if (restartCmd)
      lowCnt <= lowPer; // R6
    else if (lowStep)
      lowCnt <= stepDown(lowCnt, lowPer); // R21
  end

  // high byte down counter
  always_ff @(posedge mclk)
  begin
    if (clrAll)
      highCnt <= RST_CNT;
    else if (wrHighCnt)
      highCnt <= regWdata;
    else if (restartCmd)
      highCnt <= highPer; // R6
    else if (highStep)
      highCnt <= stepDown(highCnt, highPer); // R21
  end

  // sticky flags, hardware set wins over a one written to clear
  assign flagSet = {1'b0, lowMatch, 2'b00, highBottom, lowBottom};
  assign flagClr = (regWrite && regAddr == OFF_INT_FLAGS) ?
                   (regWdata & IRQ_MASK) : 8'h00;
  always_ff @(posedge mclk)
  begin
    if (clrAll)
      interrupt_flags <= RST_REG;
    else
      interrupt_flags <= (interrupt_flags & ~flagClr) | flagSet; // R17
  end

  // requests gated by their enables
  assign lowMatchIrq   = interrupt_flags[LOW_MATCH_LSB +: 3] &
                         intEn[LOW_MATCH_LSB +: 3]; // R14
  assign highBottomIrq = interrupt_flags[HIGH_BOTTOM_BIT] &&
                         intEn[HIGH_BOTTOM_BIT]; // R15
  assign lowBottomIrq  = interrupt_flags[LOW_BOTTOM_BIT] &&
                         intEn[LOW_BOTTOM_BIT]; // R15

  // waveform generator: compare result when running, forced when stopped
  always_ff @(posedge mclk)
  begin
    if (clrAll)
      waveOut <= 6'h00;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        waveOut[i]   <= timerOn ? (lowCnt < lowCmp[i]) :
                        forced[LOW_CHAN_LSB + i]; // R5
        waveOut[3+i] <= timerOn ? (highCnt < highCmp[i]) : // R20
                        forced[HIGH_CHAN_LSB + i]; // R5
      end
    end
  end

  // pin mux between waveform and port value
  assign chanEn = {outEn[HIGH_CHAN_LSB +: 3], outEn[LOW_CHAN_LSB +: 3]};
  assign pinOut = (waveOut & chanEn) | (portOut & ~chanEn); // R4

  // read mux; command field always reads zero
  always_comb
  begin
    readValue = 8'h00;
    if (regAddr == OFF_CTRL_CLK)
      readValue = ctrlClk;
    else if (regAddr == OFF_OUT_EN)
      readValue = outEn;
    else if (regAddr == OFF_FORCED)
      readValue = forced;
    else if (regAddr == OFF_SPLIT)
      readValue = splitCtl;
    else if (regAddr == OFF_CMD_CLR || regAddr == OFF_CMD_SET)
      readValue = {6'h00, cmdTarget}; // R8
    else if (regAddr == OFF_INT_EN)
      readValue = intEn;
    else if (regAddr == OFF_INT_FLAGS)
      readValue = interrupt_flags;
    else if (regAddr == OFF_LOW_CNT)
      readValue = lowCnt;
    else if (regAddr == OFF_HIGH_CNT)
      readValue = highCnt;
    else if (regAddr == OFF_LOW_PER)
      readValue = lowPer;
    else if (regAddr == OFF_HIGH_PER)
      readValue = highPer;
    else if (regAddr >= OFF_CMP_FIRST && regAddr <= OFF_CMP_LAST)
      readValue = regAddr[0] ? highCmp[cmpIdx] : lowCmp[cmpIdx];
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= readValue;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_stop_hold: assert property ( // R2
    !timerOn && !wrLowCnt && !restartCmd && !hardReset |=> $stable(lowCnt))
    else $error("low count moved while stopped");
  chk_split_off: assert property ( // R3
    !splitCtl[SPLIT_BIT] && !wrHighCnt && !restartCmd && !hardReset
    |=> $stable(highCnt))
    else $error("high count moved outside dual byte mode");
  chk_pin_mux: assert property ( // R4
    pinOut[3] == (outEn[HIGH_CHAN_LSB] ? waveOut[3] : portOut[3]))
    else $error("pin three shows the wrong source");
  chk_forced_level: assert property ( // R5
    !timerOn && !clrAll |=> waveOut[1] == $past(forced[1]))
    else $error("forced level not on waveform output");
  chk_hard_ignored: assert property ( // R7
    timerOn && wrCmd && cmdCode == CMD_HARD_RESET |=> timerOn)
    else $error("hard reset acted on a running timer");
  chk_cmd_reads_zero: assert property ( // R8
    regRead && (regAddr == OFF_CMD_CLR || regAddr == OFF_CMD_SET)
    |=> regRdata[CMD_LSB +: 2] == 2'b00)
    else $error("command field read back nonzero");
  chk_set_bits: assert property ( // R13
    regWrite && regAddr == OFF_CMD_SET && !hardReset
    |=> cmdTarget == ($past(cmdTarget) | $past(regWdata[1:0])))
    else $error("set register did not or in target bits");
  chk_clr_bits: assert property ( // R12
    regWrite && regAddr == OFF_CMD_CLR && !hardReset
    |=> cmdTarget == ($past(cmdTarget) & ~$past(regWdata[1:0])))
    else $error("clear register did not clear target bits");
  chk_restart_load: assert property ( // R6
    restartCmd |=> lowCnt == $past(lowPer) && highCnt == $past(highPer))
    else $error("restart did not load both periods");
  chk_match_flag: assert property ( // R16
    lowStep && lowCnt == lowCmp[0] |=> interrupt_flags[LOW_MATCH_LSB])
    else $error("low compare match left flag clear");
  chk_flag_sticky: assert property ( // R17
    interrupt_flags[LOW_BOTTOM_BIT] && !flagClr[LOW_BOTTOM_BIT] && !hardReset
    |=> interrupt_flags[LOW_BOTTOM_BIT])
    else $error("bottom flag dropped without a clear");
  chk_high_bottom: assert property ( // R18
    highBottom |=> interrupt_flags[HIGH_BOTTOM_BIT] && highCnt == $past(highPer))
    else $error("high bottom missed flag or reload");
  chk_bottom_irq: assert property ( // R15
    lowBottom && intEn[LOW_BOTTOM_BIT] && !hardReset |=> lowBottomIrq)
    else $error("enabled low bottom raised no request");
  chk_down_step: assert property ( // R21
    lowStep && lowCnt != 8'h00 |=> lowCnt == 8'($past(lowCnt) - 8'h01))
    else $error("low counter did not step down by one");
  chk_high_wave: assert property ( // R20
    timerOn && !clrAll |=> waveOut[4] == ($past(highCnt) < $past(highCmp[1])))
    else $error("high compare result not on waveform");

  cov_restart:    cover property (restartCmd);
  cov_hard_reset: cover property (hardReset);
  cov_low_bottom: cover property (lowBottom ##1 lowBottomIrq);
  cov_match_irq:  cover property (lowMatch[2] ##1 lowMatchIrq[2]);
endmodule
`default_nettype wire

/* logic/sdbt_pkg.sv */
`default_nettype none
package sdbt_pkg;
  // bus and counter widths
  localparam int ADDR_W  = 6;
  localparam int DATA_W  = 8;
  localparam int PRESC_W = 10;

  // register offsets
  localparam logic [5:0] OFF_CTRL_CLK  = 6'h00;
  localparam logic [5:0] OFF_OUT_EN    = 6'h01;
  localparam logic [5:0] OFF_FORCED    = 6'h02;
  localparam logic [5:0] OFF_SPLIT     = 6'h03;
  localparam logic [5:0] OFF_CMD_CLR   = 6'h04;
  localparam logic [5:0] OFF_CMD_SET   = 6'h05;
  localparam logic [5:0] OFF_INT_EN    = 6'h0A;
  localparam logic [5:0] OFF_INT_FLAGS = 6'h0B;
  localparam logic [5:0] OFF_LOW_CNT   = 6'h20;
  localparam logic [5:0] OFF_HIGH_CNT  = 6'h21;
  localparam logic [5:0] OFF_LOW_PER   = 6'h26;
  localparam logic [5:0] OFF_HIGH_PER  = 6'h27;
  localparam logic [5:0] OFF_CMP_FIRST = 6'h28;
  localparam logic [5:0] OFF_CMP_LAST  = 6'h2D;

  // field positions
  localparam int ENABLE_BIT      = 0;
  localparam int PRESC_LSB       = 1;
  localparam int SPLIT_BIT       = 0;
  localparam int CMD_LSB         = 2;
  localparam int TARGET_LSB      = 0;
  localparam int LOW_BOTTOM_BIT  = 0;
  localparam int HIGH_BOTTOM_BIT = 1;
  localparam int LOW_MATCH_LSB   = 4;
  localparam int LOW_CHAN_LSB    = 0;
  localparam int HIGH_CHAN_LSB   = 4;

  // writable bits of each register
  localparam logic [7:0] CTRL_MASK  = 8'h0F;
  localparam logic [7:0] CHAN_MASK  = 8'h77;
  localparam logic [7:0] SPLIT_MASK = 8'h01;
  localparam logic [7:0] IRQ_MASK   = 8'h73;

  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_CNT = 8'h00;
  localparam logic [7:0] RST_PER = 8'hFF;
  localparam logic [7:0] RST_CMP = 8'h00;

  // log2 of each division, four bits per code, code 0 lowest
  localparam logic [31:0] DIV_SHIFT = 32'hA8643210;

  typedef enum logic [1:0] {
    CMD_NONE       = 2'h0,
    CMD_RESERVED   = 2'h1,
    CMD_RESTART    = 2'h2,
    CMD_HARD_RESET = 2'h3
  } sdbt_cmd_t;

  typedef enum logic [1:0] {
    TGT_NONE     = 2'h0,
    TGT_RSVD_ONE = 2'h1,
    TGT_RSVD_TWO = 2'h2,
    TGT_BOTH     = 2'h3
  } sdbt_target_t;
endpackage
`default_nettype wire

/* logic/sdbt_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
module sdbt_prescaler
#(
  parameter int PRESC_W = sdbt_pkg::PRESC_W
)
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] select,
  output logic            tick
);
  import sdbt_pkg::*;

  logic [PRESC_W-1:0] divCount;
  logic [PRESC_W-1:0] divMask;

  // low bits that must all be one for a tick
  function automatic logic [PRESC_W-1:0] maskOf(input logic [2:0] code);
    logic [3:0] sh;
    sh = DIV_SHIFT[{code, 2'b00} +: 4];
    maskOf = PRESC_W'((1 << sh) - 1);
  endfunction

  assign divMask = maskOf(select);
  assign tick    = run && ((divCount & divMask) == divMask); // R1

  // free count while running, cleared when stopped or restarted
  always_ff @(posedge mclk)
  begin
    if (rst || !run || restart)
      divCount <= '0;
    else
      divCount <= PRESC_W'(divCount + 1'b1);
  end

  default clocking pcb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_div_one: assert property ( // R1
    run && select == 3'h0 |-> tick)
    else $error("divide by one missed a tick");
  chk_div_four: assert property ( // R1
    tick && select == 3'h2 |-> divCount[1:0] == 2'b11)
    else $error("divide by four ticked off phase");
endmodule
`default_nettype wire

/* dv/sdbt_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sdbt_pin_model
(
  input  wire logic       mclk,
  input  wire logic [5:0] portNext,
  input  wire logic [5:0] pinOut,
  output logic      [5:0] portOut,
  output logic      [5:0] pinLevel
);
  // port output register, known from time zero
  initial portOut = 6'h00;
  // port register loads what software last wrote
  always @(posedge mclk)
    portOut <= portNext;
  // pads simply follow the routed pin values
  assign pinLevel = pinOut;
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sdbt_pkg::*;
  logic       mclk;
  logic       rst;
  logic [5:0] regAddr;
  logic [7:0] regWdata;
  logic       regWrite;
  logic       regRead;
  logic [5:0] portNext;
  logic [5:0] portOut;
  logic [7:0] regRdata;
  logic [5:0] waveOut;
  logic [5:0] pinOut;
  logic [5:0] pinLevel;
  logic [2:0] lowMatchIrq;
  logic       highBottomIrq;
  logic       lowBottomIrq;
  logic       rdSeen = 1'b0;
  logic [7:0] expQ [$];
  logic [7:0] f;
  logic [7:0] e;
  logic [5:0] m;
  logic [5:0] w;
  int         n_fail;
  int         checked;
  int         cyc;
  int         seed;
  int         t0;
  int         t1;
  logic [5:0] offs [7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h04, 6'h0A};
  logic [7:0] msk [7] = '{8'h0F, 8'h77, 8'h77, 8'h01, 8'h03, 8'h00, 8'h73};
  int         divs [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

  // free running clock
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  sdbt_timer DUT (
    .regAddr       (regAddr),
    .regWdata      (regWdata),
    .regWrite      (regWrite),
    .regRead       (regRead),
    .mclk          (mclk),
    .rst           (rst),
    .portOut       (portOut),
    .regRdata      (regRdata),
    .waveOut       (waveOut),
    .pinOut        (pinOut),
    .lowMatchIrq   (lowMatchIrq),
    .highBottomIrq (highBottomIrq),
    .lowBottomIrq  (lowBottomIrq)
  );

  sdbt_pin_model pins (
    .mclk     (mclk),
    .portNext (portNext),
    .pinOut   (pinOut),
    .portOut  (portOut),
    .pinLevel (pinLevel)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one write strobe, released by whatever follows
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge mclk);
  endtask

  // read request; the expected byte waits in the queue
  task automatic rd(input logic [5:0] a, input logic [7:0] d);
    expQ.push_back(d);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  // bounded wait for the low bottom request, returns the cycle seen
  task automatic wait_low(output int t);
    int n;
    n = 0;
    // a clear written just before only shows after one more edge
    idle(1);
    while (lowBottomIrq !== 1'b1 && n < 9000)
    begin
      idle(1);
      n++;
    end
    if (n >= 9000)
      chk(32'h0, 32'h1);
    t = cyc;
  endtask

  // read data checker and cycle ceiling
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (rdSeen)
      chk({24'h0, regRdata}, {24'h0, expQ.pop_front()});
    rdSeen <= regRead && !rst;
    if (cyc > 60000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  initial
  begin
    seed = 32'hE265;
    rst = 1'b1;
    regAddr = 6'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    portNext = 6'h00;
    n_fail = 0;
    checked = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    // reset values, unmapped offset reads zero
    for (int i = 0; i < 7; i++)
      rd(offs[i], 8'h00);
    rd(OFF_INT_FLAGS, 8'h00);
    rd(OFF_LOW_PER, 8'hFF);
    rd(OFF_HIGH_PER, 8'hFF);
    rd(6'h06, 8'h00);
    // all ones written, writable bits read back; hard reset while on
    for (int i = 0; i < 7; i++)
    begin
      wr(offs[i], 8'hFF);
      rd(offs[i], msk[i]);
    end
    rd(OFF_CTRL_CLK, 8'h0F);
    // target bits through the set and clear registers
    wr(OFF_CMD_SET, 8'h01);
    rd(OFF_CMD_CLR, 8'h01);
    wr(OFF_CMD_SET, 8'h02);
    rd(OFF_CMD_SET, 8'h03);
    wr(OFF_CMD_CLR, 8'h01);
    rd(OFF_CMD_SET, 8'h02);
    wr(OFF_CMD_CLR, 8'h02);
    $display("register access test done");
    // stopped: forced levels on the waveforms, enables route pins
    wr(OFF_CTRL_CLK, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      f = 8'($random(seed)) & 8'h77;
      e = 8'($random(seed)) & 8'h77;
      portNext <= 6'($random(seed));
      wr(OFF_FORCED, f);
      wr(OFF_OUT_EN, e);
      idle(3);
      w = {f[6:4], f[2:0]};
      m = {e[6:4], e[2:0]};
      chk(waveOut, w);
      chk(pinLevel, (m & w) | (~m & portNext));
    end
    $display("forced level test done");
    // counter setup; disabled counter must hold
    wr(OFF_LOW_PER, 8'h07);
    wr(OFF_HIGH_PER, 8'hFE);
    wr(OFF_CMP_FIRST, 8'h08);
    wr(6'h29, 8'hFF);
    wr(OFF_SPLIT, 8'h01);
    wr(OFF_INT_EN, 8'h73);
    wr(OFF_OUT_EN, 8'h11);
    wr(OFF_LOW_CNT, 8'h05);
    idle(20);
    rd(OFF_LOW_CNT, 8'h05);
    // bottom interval is eight ticks of the selected division
    for (int c = 7; c >= 0; c--)
    begin
      wr(OFF_CTRL_CLK, {4'h0, 3'(c), 1'b1});
      wr(OFF_INT_FLAGS, 8'h01);
      wait_low(t0);
      wr(OFF_INT_FLAGS, 8'h01);
      wait_low(t1);
      chk(t1 - t0, 8 * divs[c]);
    end
    idle(300);
    rd(OFF_INT_FLAGS, 8'h63);
    chk(lowMatchIrq, 3'b110);
    chk(highBottomIrq, 1'b1);
    chk(waveOut, 6'h09);
    chk(pinLevel, 6'h09 | (6'h36 & portNext));
    $display("counting test done");
    // flags hold while stopped until ones are written
    wr(OFF_CTRL_CLK, 8'h00);
    idle(4);
    wr(OFF_INT_FLAGS, 8'h21);
    rd(OFF_INT_FLAGS, 8'h42);
    wr(OFF_INT_FLAGS, 8'h42);
    rd(OFF_INT_FLAGS, 8'h00);
    idle(2);
    chk(lowMatchIrq, 3'b000);
    $display("flag clear test done");
    // commands: no target, reserved code, restart, hard reset
    wr(OFF_CMD_CLR, 8'h03);
    wr(OFF_LOW_CNT, 8'h05);
    wr(OFF_CMD_SET, 8'h08);
    rd(OFF_LOW_CNT, 8'h05);
    wr(OFF_CMD_SET, 8'h07);
    rd(OFF_LOW_CNT, 8'h05);
    wr(OFF_CMD_SET, 8'h0B);
    rd(OFF_LOW_CNT, 8'h07);
    rd(OFF_HIGH_CNT, 8'hFE);
    wr(OFF_CMD_SET, 8'h0F);
    rd(OFF_LOW_PER, 8'hFF);
    rd(OFF_SPLIT, 8'h00);
    rd(OFF_CMD_SET, 8'h00);
    // enabled without dual byte mode: counters must hold
    wr(OFF_CTRL_CLK, 8'h01);
    idle(10);
    rd(OFF_HIGH_CNT, 8'h00);
    rd(OFF_LOW_CNT, 8'h00);
    wr(OFF_CTRL_CLK, 8'h00);
    idle(3);
    $display("command test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
